/* core/serial_flash_spi_front_end.sv */
// Device-side serial front end of a small serial NOR flash, Wishbone slave
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
module serial_flash_spi_front_end (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial pins
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        hold_n_i,
    input  wire logic        wp_n_i,
    input  wire logic        dual_line_low_i,
    output logic             dual_line_low_o,
    output logic             dual_line_low_oe_n_o,
    input  wire logic        dual_line_high_i,
    output logic             dual_line_high_o,
    output logic             dual_line_high_oe_n_o
);

    flash_fe_pkg::fe_state_t r;
    flash_fe_pkg::fe_state_t n;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Status byte: protect bit, reserved zero, top/bottom, block bits, latch, busy
    function automatic logic [7:0] status_byte(input flash_fe_pkg::protect_t p,
                                               input logic write_enable_latch, input logic busy);
        status_byte = {p.register_protect_bit, 1'b0, p.tb, p.bp, write_enable_latch, busy};
    endfunction

    // Region check over eight 64 KB blocks; top or bottom growing by powers of two
    function automatic logic is_protected(input flash_fe_pkg::protect_t p,
                                          input logic [23:0] a);
        logic [3:0] nblk;
        logic [3:0] blk;
        nblk = 4'h0;
        blk  = {1'b0, a[18:16]};
        if (p.bp[2]) begin
            is_protected = 1'b1;
        end else if (p.bp[1:0] == 2'b00) begin
            is_protected = 1'b0;
        end else begin
            nblk = 4'h1 << (p.bp[1:0] - 2'h1);
            if (p.tb) begin
                is_protected = blk < nblk;
            end else begin
                is_protected = blk >= (4'h8 - nblk);
            end
        end
    endfunction

    function automatic logic is_dual_read(input logic [7:0] op);
        is_dual_read = (op == flash_fe_pkg::OP_DUAL_OUT) || (op == flash_fe_pkg::OP_DUAL_IO);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic       cs_rise;
        logic       cs_fall;
        logic       rise;
        logic       fall;
        logic       req;
        logic       wr_ok;
        logic [7:0] in_byte;
        logic [7:0] src;
        logic [31:0] a_next;
        cs_rise = 1'b0;
        cs_fall = 1'b0;
        rise    = 1'b0;
        fall    = 1'b0;
        req     = 1'b0;
        wr_ok   = 1'b0;
        in_byte = 8'h00;
        src     = 8'h00;
        a_next  = 32'h0;
        n       = r;

        // Two-stage synchronisers; edges only from the second stage onward
        n.pin_m = '{cs_n: cs_n_i, sck: sck_i, hold_n: hold_n_i, wp_n: wp_n_i,
                    io0: dual_line_low_i, io1: dual_line_high_i};
        n.pin_s = r.pin_m;
        n.cs_p  = r.pin_s.cs_n;
        n.sck_p = r.pin_s.sck;
        cs_rise = r.pin_s.cs_n & ~r.cs_p;
        // cs_p resets low, so a select already low at power-up is no edge
        cs_fall = ~r.pin_s.cs_n & r.cs_p;
        rise = r.pin_s.sck & ~r.sck_p & ~r.pin_s.cs_n & ~r.paused;
        fall = ~r.pin_s.sck & r.sck_p & ~r.pin_s.cs_n & ~r.paused;

        // Power-up lockout timer
        if (r.lockout != 12'h000) begin
            n.lockout = r.lockout - 12'h001;
        end

        // Wishbone slave; every address answers, unmapped reads return zero
        req   = wb_cyc_i & wb_stb_i & ~r.ack;
        n.ack = req;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                flash_fe_pkg::REG_STATUS: begin
                    n.dat = 32'h0;
                    n.dat[7:0] = status_byte(r.prot, r.write_enable_latch, r.busy);
                    n.dat[flash_fe_pkg::STAT_PD_BIT]       = r.powered_down;
                    n.dat[flash_fe_pkg::STAT_LOCKOUT_BIT]  = r.lockout != 12'h000;
                    n.dat[flash_fe_pkg::STAT_PAUSED_BIT]   = r.paused;
                    n.dat[flash_fe_pkg::STAT_SELECTED_BIT] = ~r.pin_s.cs_n;
                end
                flash_fe_pkg::REG_CMD:  n.dat = {r.cmd_addr, r.cmd_op};
                flash_fe_pkg::REG_DATA: n.dat = {16'h0, r.byte_cnt, r.rx_byte};
                default:                n.dat = 32'h0;
            endcase
        end
        if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                flash_fe_pkg::REG_CTRL: begin
                    // Array engine reports the end of the cycle
                    if (wb_dat_i[flash_fe_pkg::CTRL_OP_DONE_BIT]) begin
                        n.busy = 1'b0;
                        n.write_enable_latch  = 1'b0;
                    end
                end
                flash_fe_pkg::REG_DATA: n.tx_byte = wb_dat_i[7:0];
                default: ;
            endcase
        end

        // Pause tracking; an edge on hold resolves only while the clock is low
        if (r.pin_s.cs_n) begin
            n.paused = 1'b0;
        end else if (!r.paused && !r.pin_s.hold_n && !r.pin_s.sck) begin
            n.paused = 1'b1;
        end else if (r.paused && r.pin_s.hold_n && !r.pin_s.sck) begin
            n.paused = 1'b0;
        end

        // Rising clock: sample the input line(s), state survives a pause
        in_byte = {r.sh_in[6:0], r.pin_s.io0};
        if (rise) begin
            case (r.phase)
                flash_fe_pkg::PH_OPCODE: begin
                    n.sh_in   = in_byte;
                    n.bit_cnt = r.bit_cnt + 5'h01;
                    if (r.bit_cnt == flash_fe_pkg::OPCODE_LAST) begin
                        n.opcode  = in_byte;
                        n.bit_cnt = 5'h00;
                        n.out_cnt = 4'h0;
                        n.byte_cnt = 8'h00;
                        if (r.powered_down && in_byte != flash_fe_pkg::OP_RELEASE_PD) begin
                            n.phase = flash_fe_pkg::PH_IGNORE;
                        end else if (r.busy && in_byte != flash_fe_pkg::OP_RD_STATUS) begin
                            n.phase = flash_fe_pkg::PH_IGNORE;
                        end else begin
                            case (in_byte)
                                flash_fe_pkg::OP_RD_STATUS: n.phase = flash_fe_pkg::PH_RDATA;
                                flash_fe_pkg::OP_READ, flash_fe_pkg::OP_FAST_READ,
                                flash_fe_pkg::OP_DUAL_OUT, flash_fe_pkg::OP_DUAL_IO,
                                flash_fe_pkg::OP_PAGE_PROG, flash_fe_pkg::OP_ERASE_4K,
                                flash_fe_pkg::OP_ERASE_32K, flash_fe_pkg::OP_ERASE_64K:
                                    n.phase = flash_fe_pkg::PH_ADDR;
                                default: n.phase = flash_fe_pkg::PH_WDATA;
                            endcase
                        end
                    end
                end
                flash_fe_pkg::PH_ADDR: begin
                    // Dual-I/O read takes address and mode byte two bits a clock
                    if (r.opcode == flash_fe_pkg::OP_DUAL_IO) begin
                        a_next = {r.addr_sh[29:0], r.pin_s.io1, r.pin_s.io0};
                    end else begin
                        a_next = {r.addr_sh[30:0], r.pin_s.io0};
                    end
                    n.addr_sh = a_next;
                    n.bit_cnt = r.bit_cnt + 5'h01;
                    if (r.opcode == flash_fe_pkg::OP_DUAL_IO &&
                        r.bit_cnt == flash_fe_pkg::ADDR_LAST_X2) begin
                        n.addr    = a_next[31:8];
                        n.bit_cnt = 5'h00;
                        n.phase   = flash_fe_pkg::PH_RDATA;
                    end else if (r.opcode != flash_fe_pkg::OP_DUAL_IO &&
                                 r.bit_cnt == flash_fe_pkg::ADDR_LAST_X1) begin
                        n.addr    = a_next[23:0];
                        n.bit_cnt = 5'h00;
                        case (r.opcode)
                            flash_fe_pkg::OP_READ:      n.phase = flash_fe_pkg::PH_RDATA;
                            flash_fe_pkg::OP_FAST_READ,
                            flash_fe_pkg::OP_DUAL_OUT:  n.phase = flash_fe_pkg::PH_DUMMY;
                            default:                    n.phase = flash_fe_pkg::PH_WDATA;
                        endcase
                    end
                end
                flash_fe_pkg::PH_DUMMY: begin
                    n.bit_cnt = r.bit_cnt + 5'h01;
                    if (r.bit_cnt == flash_fe_pkg::DUMMY_LAST) begin
                        n.bit_cnt = 5'h00;
                        n.phase   = flash_fe_pkg::PH_RDATA;
                    end
                end
                flash_fe_pkg::PH_WDATA: begin
                    n.sh_in   = in_byte;
                    n.bit_cnt = r.bit_cnt + 5'h01;
                    if (r.bit_cnt == flash_fe_pkg::OPCODE_LAST) begin
                        n.bit_cnt = 5'h00;
                        n.rx_byte = in_byte;
                        if (r.byte_cnt == 8'h00) begin
                            n.wr_status = in_byte;
                        end
                        if (r.byte_cnt != 8'hff) begin
                            n.byte_cnt = r.byte_cnt + 8'h01;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Falling clock: shift the next bit(s) out, refilling each byte
        if (fall && r.phase == flash_fe_pkg::PH_RDATA) begin
            if (r.out_cnt == 4'h0) begin
                src = (r.opcode == flash_fe_pkg::OP_RD_STATUS) ?
                      status_byte(r.prot, r.write_enable_latch, r.busy) : r.tx_byte;
            end else begin
                src = r.out_sh;
            end
            if (is_dual_read(r.opcode)) begin
                n.do_hi   = src[7];
                n.do_lo   = src[6];
                n.drv_lo  = 1'b1;
                n.out_sh  = {src[5:0], 2'b00};
                n.out_cnt = ((r.out_cnt == 4'h0) ? flash_fe_pkg::BITS_PER_BYTE : r.out_cnt)
                            - 4'h2;
            end else begin
                n.do_hi   = src[7];
                n.out_sh  = {src[6:0], 1'b0};
                n.out_cnt = ((r.out_cnt == 4'h0) ? flash_fe_pkg::BITS_PER_BYTE : r.out_cnt)
                            - 4'h1;
            end
            n.drv_hi = 1'b1;
        end

        // Output floats unless selected, unpaused and in a read phase
        if (r.pin_s.cs_n || n.paused || r.phase != flash_fe_pkg::PH_RDATA) begin
            n.drv_hi = 1'b0;
            n.drv_lo = 1'b0;
        end

        // Select fall opens a new instruction
        if (cs_fall) begin
            n.phase   = flash_fe_pkg::PH_OPCODE;
            n.bit_cnt = 5'h00;
        end

        // Select rise: execute write-type work on a byte boundary, then idle
        if (cs_rise) begin
            wr_ok = r.phase == flash_fe_pkg::PH_WDATA && r.bit_cnt == 5'h00;
            if (wr_ok) begin
                case (r.opcode)
                    flash_fe_pkg::OP_WR_ENABLE: begin
                        if (r.lockout == 12'h000) begin
                            n.write_enable_latch = 1'b1;
                        end
                    end
                    flash_fe_pkg::OP_WR_DISABLE: n.write_enable_latch = 1'b0;
                    flash_fe_pkg::OP_WR_STATUS: begin
                        if (r.write_enable_latch && r.lockout == 12'h000 && r.byte_cnt != 8'h00 &&
                            !(r.prot.register_protect_bit && !r.pin_s.wp_n)) begin
                            n.prot = '{register_protect_bit: r.wr_status[7], tb: r.wr_status[5],
                                       bp: r.wr_status[4:2]};
                            n.busy = 1'b1;
                        end
                    end
                    flash_fe_pkg::OP_PAGE_PROG: begin
                        if (r.write_enable_latch && r.lockout == 12'h000 && r.byte_cnt != 8'h00 &&
                            !is_protected(r.prot, r.addr)) begin
                            n.busy = 1'b1;
                        end
                    end
                    flash_fe_pkg::OP_ERASE_4K, flash_fe_pkg::OP_ERASE_32K,
                    flash_fe_pkg::OP_ERASE_64K: begin
                        if (r.write_enable_latch && r.lockout == 12'h000 &&
                            !is_protected(r.prot, r.addr)) begin
                            n.busy = 1'b1;
                        end
                    end
                    flash_fe_pkg::OP_ERASE_CHIP, flash_fe_pkg::OP_ERASE_CHIP2: begin
                        if (r.write_enable_latch && r.lockout == 12'h000 &&
                            r.prot.bp == flash_fe_pkg::BLOCKS_IN_MAP) begin
                            n.busy = 1'b1;
                        end
                    end
                    flash_fe_pkg::OP_POWER_DOWN: n.powered_down = 1'b1;
                    flash_fe_pkg::OP_RELEASE_PD: n.powered_down = 1'b0;
                    default: ;
                endcase
                // Hand the accepted cycle to the array engine; this set wins over done
                if (n.busy && !r.busy) begin
                    n.cmd_op   = r.opcode;
                    n.cmd_addr = r.addr;
                end
            end
            n.phase    = flash_fe_pkg::PH_IDLE;
            n.bit_cnt  = 5'h00;
            n.drv_hi   = 1'b0;
            n.drv_lo   = 1'b0;
            n.paused   = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset doubles as the internal power-on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r         <= '0;
            r.lockout <= flash_fe_pkg::LOCKOUT_CYCLES;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o              = r.ack;
    assign wb_dat_o              = r.dat;
    assign dual_line_high_o      = r.do_hi;
    assign dual_line_low_o       = r.do_lo;
    assign dual_line_high_oe_n_o = ~r.drv_hi; // Low while driving
    assign dual_line_low_oe_n_o  = ~r.drv_lo;

endmodule

/* core/flash_fe_pkg.sv */
// Constants, phases and carrier structs of the serial flash front end
package flash_fe_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction codes
    localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
    localparam logic [7:0] OP_RD_STATUS   = 8'h05;
    localparam logic [7:0] OP_WR_STATUS   = 8'h01;
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT    = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO     = 8'hbb;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_ERASE_4K    = 8'h20;
    localparam logic [7:0] OP_ERASE_32K   = 8'h52;
    localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
    localparam logic [7:0] OP_ERASE_CHIP  = 8'hc7;
    localparam logic [7:0] OP_ERASE_CHIP2 = 8'h60;
    localparam logic [7:0] OP_POWER_DOWN  = 8'hb9;
    localparam logic [7:0] OP_RELEASE_PD  = 8'hab;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_DATA   = 8'h0c;

    // Field positions
    localparam int CTRL_OP_DONE_BIT   = 0;
    localparam int STAT_PD_BIT        = 8;
    localparam int STAT_LOCKOUT_BIT   = 9;
    localparam int STAT_PAUSED_BIT    = 10;
    localparam int STAT_SELECTED_BIT  = 11;
    localparam int DATA_COUNT_LSB     = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Serial counts
    localparam logic [4:0] OPCODE_LAST    = 5'h07;
    localparam logic [4:0] ADDR_LAST_X1   = 5'h17;
    localparam logic [4:0] ADDR_LAST_X2   = 5'h0f;
    localparam logic [4:0] DUMMY_LAST     = 5'h07;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [2:0] BLOCKS_IN_MAP  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS         = 5;
    localparam int LOCKOUT_NS            = 10000;
    localparam logic [11:0] LOCKOUT_CYCLES = 12'(LOCKOUT_NS / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        PH_IDLE, PH_OPCODE, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_IGNORE
    } phase_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic hold_n;
        logic wp_n;
        logic io0;
        logic io1;
    } pins_t;

    typedef struct packed {
        logic       register_protect_bit;
        logic       tb;
        logic [2:0] bp;
    } protect_t;

    typedef struct packed {
        pins_t      pin_m;
        pins_t      pin_s;
        logic       cs_p;
        logic       sck_p;
        logic       paused;
        phase_t     phase;
        logic [4:0] bit_cnt;
        logic [7:0] byte_cnt;
        logic [7:0] sh_in;
        logic [7:0] opcode;
        logic [31:0] addr_sh;
        logic [23:0] addr;
        logic [7:0] wr_status;
        logic [7:0] out_sh;
        logic [3:0] out_cnt;
        logic       do_hi;
        logic       do_lo;
        logic       drv_hi;
        logic       drv_lo;
        protect_t   prot;
        logic       write_enable_latch;
        logic       busy;
        logic       powered_down;
        logic [11:0] lockout;
        logic [7:0] cmd_op;
        logic [23:0] cmd_addr;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic       ack;
        logic [31:0] dat;
    } fe_state_t;

endpackage

/* test/fe_assertions.sv */
// Port checker for the serial flash front end
module fe_checker (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Serial pins
    input wire logic        cs_n_i,
    input wire logic        sck_i,
    input wire logic        hold_n_i,
    input wire logic        dual_line_high_o,
    input wire logic        dual_line_low_oe_n_o,
    input wire logic        dual_line_high_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Margins of 8 samples cover the pin synchronisers
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && dual_line_high_oe_n_o && dual_line_low_oe_n_o)
        else $error("outputs active out of reset");
    a_select_float: assert property (cs_n_i [*8] |-> dual_line_high_oe_n_o && dual_line_low_oe_n_o)
        else $error("pin driven while deselected");
    a_pause_float: assert property ((!cs_n_i && !hold_n_i && !sck_i) [*8] |-> dual_line_high_oe_n_o)
        else $error("pin driven while paused");
    a_io0_with_io1: assert property (!dual_line_low_oe_n_o |-> !dual_line_high_oe_n_o)
        else $error("low line driven outside dual read");
    a_out_hold_high: assert property ((!cs_n_i && sck_i) [*8] |-> $stable(dual_line_high_o))
        else $error("output changed while clock high");
endmodule

bind serial_flash_spi_front_end fe_checker u_fe_checker (.*);

/* test/spi_host_model.sv */
// Behavioural SPI host for the flash front end
module spi_host_model (
    // Host drives
    output logic cs_n_o,
    output logic sck_o,
    output logic hold_n_o,
    output logic di_o,
    // Shared data lines
    input wire logic io0_i,
    input wire logic io1_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        hold_n_o = 1'b1;
        di_o = 1'b0;
    end
    // One framed transfer; clock stands still outside it, MSB first
    task automatic frame(input logic [47:0] tx, input int n, input bit m3, input int hp,
                         output logic [7:0] r1, output logic [7:0] r0);
        r1 = 8'h00;
        r0 = 8'h00;
        sck_o = m3;
        #20 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            sck_o = 1'b0;
            di_o = tx[n-1-i];
            // Pause with clock low, one stray clock, select kept low
            if (i == hp) begin
                #20 hold_n_o = 1'b0;
                #40 sck_o = 1'b1;
                #40 sck_o = 1'b0;
                #60 hold_n_o = 1'b1;
            end
            #62.5 sck_o = 1'b1;
            r1 = {r1[6:0], io1_i};
            r0 = {r0[6:0], io0_i};
            #62.5;
        end
        if (!m3)
            sck_o = 1'b0;
        #20 cs_n_o = 1'b1;
        #100;
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the serial flash front end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wp_n = 1'b1;
    logic [7:0]  adr = 8'h00, r1, r0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, cs_n, sck, hold_n, di, o0, oe0, o1, oe1, io0, io1;
    int          mismatches = 0, tests_run = 0;
    // Released high line follows the clock and released low line carries host data, so a missing drive never reads as data
    assign io0 = oe0 ? di : o0;
    assign io1 = oe1 ? sck : o1;
    always #2.5 clk_i = ~clk_i;
    //////////////////////////////////////////////////////////////////
    serial_flash_spi_front_end u_serial_flash_spi_front_end (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cs_n_i(cs_n), .sck_i(sck), .hold_n_i(hold_n), .wp_n_i(wp_n),
        .dual_line_low_i(io0), .dual_line_low_o(o0), .dual_line_low_oe_n_o(oe0),
        .dual_line_high_i(io1), .dual_line_high_o(o1), .dual_line_high_oe_n_o(oe1));
    spi_host_model u_spi_host_model (.cs_n_o(cs_n), .sck_o(sck), .hold_n_o(hold_n),
        .di_o(di), .io0_i(io0), .io1_i(io1));
    //////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Classic cycle; ack and data are taken at the rising edge that sees ack high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            $display("ERROR %0t bus timeout", $time);
            complete_run();
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, flash_fe_pkg::REG_STATUS, 32'h0);
        chk(q & m, e);
    endtask
    task automatic f(input logic [47:0] t, input int n, input bit m = 1'b0, input int hp = 99);
        u_spi_host_model.frame(t, n, m, hp, r1, r0);
    endtask
    task automatic done();
        wb(1'b1, flash_fe_pkg::REG_CTRL, 32'h1);
    endtask
    //////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        st(32'h2ff, 32'h200);
        f(48'h06, 8);
        st(32'h2ff, 32'h200);
        for (int i = 0; i < 1000 && q[9] !== 1'b0; i++) wb(1'b0, flash_fe_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[9]}, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        f(48'h020001005a, 40);
        st(32'h3, 32'h0);
        f(48'h06, 8, 1'b1);
        st(32'h3, 32'h2);
        f(48'h010000802d, 39);
        st(32'h3, 32'h2);
        f(48'h020001005a, 40);
        st(32'h3, 32'h3);
        wb(1'b0, flash_fe_pkg::REG_CMD, 32'h0);
        chk(q, 32'h00010002);
        f(48'h04, 8);
        f(48'h0500, 16, 1'b0, 11);
        chk({24'h0, r1}, 32'h03);
        done();
        st(32'h3, 32'h0);
        f(48'h06, 8);
        f(48'h0184, 16);
        done();
        wp_n <= 1'b0;
        f(48'h06, 8);
        f(48'h0100, 16);
        st(32'hff, 32'h86);
        f(48'h02070000aa, 40);
        st(32'h1, 32'h0);
        wp_n <= 1'b1;
        f(48'h0100, 16);
        done();
        st(32'hff, 32'h0);
        f(48'hb9, 8);
        f(48'h06, 8);
        st(32'h102, 32'h100);
        f(48'hab, 8);
        st(32'h100, 32'h0);
        wb(1'b1, flash_fe_pkg::REG_DATA, 32'ha5);
        f(48'h03b000000000, 44);
        chk({r1[3:0], r0[3:0]}, 32'hc3);
        complete_run();
    end
endmodule
